// File: nvc_consts.svh
// Constants of the nonvolatile memory command controller.
`ifndef NVC_CONSTS_SVH
`define NVC_CONSTS_SVH
`define NVC_OFS_CMD     4'h0
`define NVC_OFS_LOCK    4'h1
`define NVC_OFS_STATUS  4'h2
`define NVC_OFS_IRQEN   4'h3
`define NVC_OFS_IRQFLG  4'h4
`define NVC_OFS_DATAL   4'h6
`define NVC_OFS_DATAH   4'h7
`define NVC_OFS_ADDRL   4'h8
`define NVC_OFS_ADDRH   4'h9
`define NVC_OFS_SYSCTL  4'ha
`define NVC_BIT_APP_CODE_WRITE_PROTECT   0
`define NVC_BIT_BOOTLK  1
`define NVC_BIT_FLASH_BUSY_FLAG   0
`define NVC_BIT_EEPROM_BUSY_FLAG  1
`define NVC_BIT_WRERR   2
`define NVC_BIT_EERDY   0
`define NVC_KEY_WINDOW  3'h4
`define NVC_PBC_CYCLES  8'h07
`define NVC_FLASH_OP_CYC 16'h0040
`define NVC_EE_OP_CYC    16'h0020
`define NVC_CHIP_OP_CYC  16'h0100
`endif

// File: nvc_cpu_model.sv
// Behavioural CPU core that retires instructions and writes the unlock key.
`timescale 1ns/1ps
module nvc_cpu_model
(
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic cpu_stall,
	input  wire logic key_req,
	output logic      cpu_key_written,
	output logic      cpu_insn_done
);
	// ----------------------------------------
	// One instruction a cycle unless stalled.
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		cpu_key_written <= nrst & key_req & ~cpu_stall;
		cpu_insn_done   <= nrst & ~cpu_stall;
	end
endmodule : nvc_cpu_model

// File: nvc_ctrl.sv
// Command sequencer for on-chip program flash, data EEPROM and fuses.
//Contract
// - EEPROM touches only updated buffer bytes
// - Command write needs key within four
// - Page write; CPU stalled for flash
// - Buffer cleared after write or erase
// - Erase needs one buffered byte
// - Flash erase whole page, CPU halted
// - EEPROM erase marked bytes, CPU runs
// - Erase then write, no clear between
// - Buffer clear, CPU halted seven cycles
// - Chip erase ignores locks, preserve fuse
// - EEPROM erase all, CPU halted
// - Fuse write only from debug port
// - Fuses readable by plain read
// - Reset aborts any write
// - Interrupt while enable and flag set
// - Write keeps running through sleep
// - Ready interrupt wakes from idle only
// - Buffer cleared on wake; ready-interrupt wake clears marks, keeps data bytes
// - Three-bit command decode
// - Busy and write error status bits
// - Ready flag set when idle, W1C
// - Write protect sticky; boot lock hides boot
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_ctrl
#(
	parameter int PAGE_BYTES = 64,
	parameter int IDX_W      = 6
)
(
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [3:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [7:0]            reg_rdata,
	input  wire logic             dbg_access,
	input  wire logic             cpu_key_written,
	input  wire logic             cpu_insn_done,
	input  wire logic             cpu_in_boot,
	input  wire logic             buf_wr,
	input  wire logic [15:0]      buf_addr,
	input  wire logic [7:0]       buf_wdata,
	input  wire logic             buf_is_eeprom,
	input  wire logic             buf_prot_area,
	input  wire logic             sleep_req,
	input  wire logic             sleep_idle,
	input  wire logic             wake,
	input  wire logic             eeprom_preserve_fuse,
	input  wire logic             boot_access,
	input  wire logic [7:0]       mem_rdata_in,
	output logic [7:0]            mem_rdata_out,
	output logic                  cpu_stall,
	output logic                  irq,
	output logic                  wake_req,
	output logic                  ctrl_asleep,
	output logic                  clk_keep_on,
	output logic                  mem_op_go,
	output logic [2:0]            mem_op_cmd,
	output logic                  mem_op_eeprom,
	output logic                  mem_op_erase_all,
	output logic                  mem_op_skip_ee,
	output logic [15:0]           mem_op_addr,
	output logic [PAGE_BYTES-1:0] mem_op_mask,
	output logic [15:0]           fuse_addr,
	output logic [15:0]           fuse_data
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		nvc_pkg::nvc_state_t    st;
		nvc_pkg::nvc_cmd_t      cmd;
		logic                   tgt_ee;
		logic                   erwr;
		logic [2:0]             key_win;
		logic                   app_code_write_protect;
		logic                   boot_read_lock;
		logic                   flash_busy_flag;
		logic                   eeprom_busy_flag;
		logic                   wrerr;
		logic                   irqen;
		logic                   eerdy;
		logic [15:0]            data;
		logic [15:0]            addr;
		logic [PAGE_BYTES-1:0]  mark;
		logic [7:0]             pbc_cnt;
		logic                   asleep;
		logic [7:0]             rdata;
		logic [7:0]             mrd;
		logic                   stall;
		logic                   irq;
		logic                   wake;
		logic                   go;
		logic                   erase_all;
		logic                   skip_ee;
		logic                   keep;
	} nvc_ctl_t;
	nvc_ctl_t s_q;
	nvc_ctl_t s_d;

	logic [7:0] pbuf_q [PAGE_BYTES];
	logic       tmr_load;
	logic [15:0] tmr_count;
	logic       tmr_done;

	function automatic logic [15:0] op_cycles(input logic ee, input nvc_pkg::nvc_cmd_t c);
		if (c == nvc_pkg::NVC_CMD_CHIP)
			op_cycles = `NVC_CHIP_OP_CYC;
		else if (ee)
			op_cycles = `NVC_EE_OP_CYC;
		else
			op_cycles = `NVC_FLASH_OP_CYC;
	endfunction : op_cycles

	nvc_op_timer u_tmr
	(
		.mclk  (mclk),
		.nrst  (nrst),
		.ce    (ce),
		.load  (tmr_load),
		.count (tmr_count),
		.done  (tmr_done)
	);

	wire logic [IDX_W-1:0] buf_idx = buf_addr[IDX_W-1:0];
	wire logic busy = s_q.flash_busy_flag | s_q.eeprom_busy_flag;
	// A store into another section or a protected area marks the last operation as failed.
	wire logic store_err = buf_wr && ((s_q.mark != '0 && s_q.tgt_ee != buf_is_eeprom) ||
		buf_prot_area || (s_q.app_code_write_protect && !buf_is_eeprom));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		tmr_load = 1'b0;
		tmr_count = 16'h0000;
		s_d.go = 1'b0;
		s_d.rdata = 8'h00;
		s_d.wake = 1'b0;
		// Key window counts down on each completed CPU instruction.
		if (cpu_key_written)
			s_d.key_win = `NVC_KEY_WINDOW;
		else if (cpu_insn_done && s_q.key_win != 3'h0)
			s_d.key_win = s_q.key_win - 3'h1;
		// Buffer loads mark bytes and track the target page.
		if (buf_wr)
		begin
			s_d.mark[buf_idx] = 1'b1;
			s_d.addr = buf_addr;
			s_d.wrerr = s_q.wrerr | store_err;
			s_d.tgt_ee = buf_is_eeprom;
		end
		// Register writes.
		if (reg_wr)
		begin
			unique case (reg_addr)
				`NVC_OFS_CMD:
				begin
					if (s_q.st == nvc_pkg::NVC_ST_IDLE && !busy &&
						(dbg_access || s_q.key_win != 3'h0))
					begin
						s_d.cmd = nvc_pkg::nvc_cmd_t'(reg_wdata[2:0]);
						s_d.key_win = 3'h0;
						// A store error raised in this same cycle survives the clear.
						s_d.wrerr = store_err;
						s_d.erwr = 1'b0;
						s_d.erase_all = 1'b0;
						s_d.skip_ee = 1'b0;
						unique case (nvc_pkg::nvc_cmd_t'(reg_wdata[2:0]))
							nvc_pkg::NVC_CMD_NONE: ;
							nvc_pkg::NVC_CMD_WRITE:
							begin
								s_d.st = nvc_pkg::NVC_ST_WRITE;
								tmr_load = 1'b1;
								tmr_count = op_cycles(s_q.tgt_ee, nvc_pkg::NVC_CMD_WRITE);
							end
							nvc_pkg::NVC_CMD_ERASE, nvc_pkg::NVC_CMD_ERWR:
							begin
								if (s_q.mark != '0)
								begin
									s_d.st = nvc_pkg::NVC_ST_ERASE;
									s_d.erwr = reg_wdata[2:0] == 3'h3;
									tmr_load = 1'b1;
									tmr_count = op_cycles(s_q.tgt_ee, nvc_pkg::NVC_CMD_ERASE);
								end
							end
							nvc_pkg::NVC_CMD_PBC:
							begin
								s_d.st = nvc_pkg::NVC_ST_CLEAR;
								s_d.pbc_cnt = `NVC_PBC_CYCLES;
							end
							nvc_pkg::NVC_CMD_CHIP:
							begin
								s_d.st = nvc_pkg::NVC_ST_ERASE;
								s_d.erase_all = 1'b1;
								s_d.skip_ee = eeprom_preserve_fuse;
								s_d.tgt_ee = 1'b0;
								tmr_load = 1'b1;
								tmr_count = op_cycles(1'b0, nvc_pkg::NVC_CMD_CHIP);
							end
							nvc_pkg::NVC_CMD_EEPROM_ERASE_CMD:
							begin
								s_d.st = nvc_pkg::NVC_ST_ERASE;
								s_d.erase_all = 1'b1;
								s_d.tgt_ee = 1'b1;
								tmr_load = 1'b1;
								tmr_count = op_cycles(1'b1, nvc_pkg::NVC_CMD_EEPROM_ERASE_CMD);
							end
							nvc_pkg::NVC_CMD_FUSE:
							begin
								if (dbg_access)
								begin
									s_d.st = nvc_pkg::NVC_ST_WRITE;
									tmr_load = 1'b1;
									tmr_count = op_cycles(1'b1, nvc_pkg::NVC_CMD_FUSE);
								end
							end
						endcase
						s_d.go = tmr_load;
						if (tmr_load)
						begin
							s_d.flash_busy_flag = !s_d.tgt_ee || s_d.erase_all &&
								reg_wdata[2:0] == 3'h5;
							s_d.eeprom_busy_flag = s_d.tgt_ee || (reg_wdata[2:0] == 3'h5 &&
								!eeprom_preserve_fuse);
						end
					end
				end
				`NVC_OFS_LOCK:
				begin
					if (reg_wdata[`NVC_BIT_APP_CODE_WRITE_PROTECT])
						s_d.app_code_write_protect = 1'b1;
					if (reg_wdata[`NVC_BIT_BOOTLK] && cpu_in_boot)
						s_d.boot_read_lock = 1'b1;
				end
				`NVC_OFS_IRQEN: s_d.irqen = reg_wdata[`NVC_BIT_EERDY];
				`NVC_OFS_IRQFLG:
					if (reg_wdata[`NVC_BIT_EERDY])
						s_d.eerdy = 1'b0;
				`NVC_OFS_DATAL: s_d.data[7:0] = reg_wdata;
				`NVC_OFS_DATAH: s_d.data[15:8] = reg_wdata;
				`NVC_OFS_ADDRL: s_d.addr[7:0] = reg_wdata;
				`NVC_OFS_ADDRH: s_d.addr[15:8] = reg_wdata;
				default: ;
			endcase
		end
		// Operation sequencing.
		unique case (s_q.st)
			nvc_pkg::NVC_ST_IDLE: ;
			nvc_pkg::NVC_ST_ERASE:
				if (tmr_done)
				begin
					if (s_q.erwr)
					begin
						s_d.st = nvc_pkg::NVC_ST_WRITE;
						tmr_load = 1'b1;
						tmr_count = op_cycles(s_q.tgt_ee, nvc_pkg::NVC_CMD_WRITE);
						s_d.go = 1'b1;
						s_d.erwr = 1'b0;
						s_d.erase_all = 1'b0;
					end
					else
						s_d.st = nvc_pkg::NVC_ST_CLEAR;
				end
			nvc_pkg::NVC_ST_WRITE:
				if (tmr_done)
					s_d.st = nvc_pkg::NVC_ST_CLEAR;
			nvc_pkg::NVC_ST_CLEAR:
			begin
				s_d.mark = '0;
				s_d.flash_busy_flag = 1'b0;
				s_d.eeprom_busy_flag = 1'b0;
				if (s_q.pbc_cnt > 8'h01)
					s_d.pbc_cnt = s_q.pbc_cnt - 8'h01;
				else
				begin
					s_d.pbc_cnt = 8'h00;
					s_d.st = nvc_pkg::NVC_ST_IDLE;
				end
			end
		endcase
		// Ready flag is set continuously while EEPROM is idle; set wins over clear.
		if (!s_d.eeprom_busy_flag)
			s_d.eerdy = 1'b1;
		s_d.irq = s_d.irqen & s_d.eerdy;
		// Sleep: stay awake while an operation runs.
		s_d.keep = s_d.st != nvc_pkg::NVC_ST_IDLE;
		if (sleep_req && s_d.st == nvc_pkg::NVC_ST_IDLE)
			s_d.asleep = 1'b1;
		if (s_q.asleep && sleep_idle && s_q.irq)
			s_d.wake = 1'b1;
		if (s_q.asleep && (wake || s_d.wake))
		begin
			s_d.asleep = 1'b0;
			s_d.mark = '0;
		end
		// The closing clear of an EEPROM operation leaves the CPU running.
		s_d.stall = (s_d.st != nvc_pkg::NVC_ST_IDLE && !s_d.tgt_ee) ||
			(s_d.st == nvc_pkg::NVC_ST_CLEAR && s_d.pbc_cnt != 8'h00) ||
			(s_d.erase_all && s_d.st == nvc_pkg::NVC_ST_ERASE);
		// Memory reads pass through; boot area reads zero when locked.
		s_d.mrd = (s_q.boot_read_lock && boot_access) ? 8'h00 : mem_rdata_in;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`NVC_OFS_CMD:    s_d.rdata = {5'h00, s_q.cmd};
				`NVC_OFS_LOCK:   s_d.rdata = {6'h00, s_q.boot_read_lock, s_q.app_code_write_protect};
				`NVC_OFS_STATUS: s_d.rdata = {5'h00, s_q.wrerr, s_q.eeprom_busy_flag, s_q.flash_busy_flag};
				`NVC_OFS_IRQEN:  s_d.rdata = {7'h00, s_q.irqen};
				`NVC_OFS_IRQFLG: s_d.rdata = {7'h00, s_q.eerdy};
				`NVC_OFS_DATAL:  s_d.rdata = s_q.data[7:0];
				`NVC_OFS_DATAH:  s_d.rdata = s_q.data[15:8];
				`NVC_OFS_ADDRL:  s_d.rdata = s_q.addr[7:0];
				`NVC_OFS_ADDRH:  s_d.rdata = s_q.addr[15:8];
				`NVC_OFS_SYSCTL: s_d.rdata = {6'h00, s_q.keep, s_q.asleep};
				default:         s_d.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			s_q <= '0;
			s_q.eerdy <= 1'b1;
		end
		else if (ce)
			s_q <= s_d;
	end

	// Page buffer storage: loads AND into the old byte; clears set all ones.
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < PAGE_BYTES; i++)
		begin
			if (!nrst)
				pbuf_q[i] <= 8'hff;
			else if (ce)
			begin
				if (s_q.st == nvc_pkg::NVC_ST_CLEAR || (s_q.asleep && wake))
					pbuf_q[i] <= 8'hff;
				else if (buf_wr && buf_idx == i[IDX_W-1:0])
					pbuf_q[i] <= pbuf_q[i] & buf_wdata;
			end
		end
	end

	assign reg_rdata        = s_q.rdata;
	assign mem_rdata_out    = s_q.mrd;
	assign cpu_stall        = s_q.stall;
	assign irq              = s_q.irq;
	assign wake_req         = s_q.wake;
	assign ctrl_asleep      = s_q.asleep;
	assign clk_keep_on      = s_q.keep;
	assign mem_op_go        = s_q.go;
	assign mem_op_cmd       = s_q.cmd;
	assign mem_op_eeprom    = s_q.tgt_ee;
	assign mem_op_erase_all = s_q.erase_all;
	assign mem_op_skip_ee   = s_q.skip_ee;
	assign mem_op_addr      = s_q.addr;
	assign mem_op_mask      = s_q.mark;
	assign fuse_addr        = s_q.addr;
	assign fuse_data        = s_q.data;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_KEYLESS_CMD: assert property (@(posedge mclk) disable iff (!nrst)
		ce && reg_wr && reg_addr == `NVC_OFS_CMD && !dbg_access && s_q.key_win == 3'h0
		|=> s_q.cmd == $past(s_q.cmd)) else $error("command taken without key");
	AST_FUSE_DBG: assert property (@(posedge mclk) disable iff (!nrst)
		ce && reg_wr && reg_addr == `NVC_OFS_CMD && !dbg_access && reg_wdata[2:0] == 3'h7
		|=> !s_q.go) else $error("fuse write started by cpu");
	AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!nrst)
		ce |=> irq == (s_q.irqen & s_q.eerdy)) else $error("irq not enable and flag");
	AST_ERASE_EMPTY: assert property (@(posedge mclk) disable iff (!nrst)
		ce && reg_wr && reg_addr == `NVC_OFS_CMD && reg_wdata[2:0] == 3'h2 && s_q.mark == '0
		|=> s_q.st == nvc_pkg::NVC_ST_IDLE) else $error("erase with empty buffer");
	AST_FLASH_STALL: assert property (@(posedge mclk) disable iff (!nrst)
		ce && s_q.flash_busy_flag && !s_q.tgt_ee |-> cpu_stall) else $error("flash busy without stall");
	AST_READY_IDLE: assert property (@(posedge mclk) disable iff (!nrst)
		ce && !s_q.eeprom_busy_flag |=> s_q.eerdy) else $error("ready flag not set when idle");
	AST_APP_CODE_WRITE_PROTECT_STICKY: assert property (@(posedge mclk) disable iff (!nrst)
		s_q.app_code_write_protect |=> s_q.app_code_write_protect) else $error("write protect cleared");
	AST_CLEAR_DONE: assert property (@(posedge mclk) disable iff (!nrst)
		ce && s_q.st == nvc_pkg::NVC_ST_CLEAR |=> s_q.mark == '0) else $error("buffer not cleared");
	AST_BOOT_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
		ce && s_q.boot_read_lock && boot_access |=> mem_rdata_out == 8'h00) else $error("locked boot read");
	sequence pbc_taken;
		ce && reg_wr && reg_addr == `NVC_OFS_CMD && reg_wdata[2:0] == 3'h4 &&
			s_q.st == nvc_pkg::NVC_ST_IDLE && !busy && (dbg_access || s_q.key_win != 3'h0);
	endsequence
	sequence stall_seven;
		cpu_stall [*7] ##1 !cpu_stall;
	endsequence
	AST_PBC_STALL: assert property (@(posedge mclk) disable iff (!nrst)
		pbc_taken |=> stall_seven) else $error("buffer clear stall not seven cycles");
endmodule : nvc_ctrl

// File: nvc_ctrl_tb.sv
// Self-checking testbench of the nonvolatile memory command controller.
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_ctrl_tb;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        dbg_access = 1'b0;
	logic        key_req = 1'b0;
	logic        buf_wr = 1'b0;
	logic [15:0] buf_addr = 16'h0000;
	logic [7:0]  buf_wdata = 8'h00;
	logic        buf_is_eeprom = 1'b0;
	logic        buf_prot_area = 1'b0;
	logic        preserve = 1'b0;
	logic        in_boot = 1'b0;
	logic        boot_acc = 1'b0;
	logic        sleep_req = 1'b0;
	logic        sleep_idle = 1'b0;
	logic        wake = 1'b0;
	logic [7:0]  mem_in = 8'h00;
	logic [7:0]  reg_rdata, mem_rdata_out, rv;
	logic        cpu_key_written, cpu_insn_done, cpu_stall, irq, mem_op_go;
	logic        mem_op_eeprom, mem_op_skip_ee, go_skip;
	logic [2:0]  mem_op_cmd, go_cmd;
	logic [63:0] mem_op_mask, go_mask;
	logic [15:0] fuse_addr, fuse_data;
	logic [31:0] seed = 32'h0000b734;
	int          err_count = 0;
	int          n_checks = 0;
	int          go_cnt = 0;
	int          stall_cnt = 0;
	int          g;
	int          marked[$];
	nvc_cpu_model u_cpu
	(
		.mclk(mclk), .nrst(nrst), .cpu_stall(cpu_stall), .key_req(key_req),
		.cpu_key_written(cpu_key_written), .cpu_insn_done(cpu_insn_done)
	);
	nvc_ctrl #(.PAGE_BYTES(64), .IDX_W(6)) u_dut
	(
		.mclk(mclk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dbg_access(dbg_access),
		.cpu_key_written(cpu_key_written), .cpu_insn_done(cpu_insn_done),
		.cpu_in_boot(in_boot), .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
		.buf_is_eeprom(buf_is_eeprom), .buf_prot_area(buf_prot_area), .sleep_req(sleep_req),
		.sleep_idle(sleep_idle), .wake(wake), .eeprom_preserve_fuse(preserve),
		.boot_access(boot_acc),
		.mem_rdata_in(mem_in), .mem_rdata_out(mem_rdata_out), .cpu_stall(cpu_stall),
		.irq(irq), .wake_req(), .ctrl_asleep(), .clk_keep_on(), .mem_op_go(mem_op_go),
		.mem_op_cmd(mem_op_cmd), .mem_op_eeprom(mem_op_eeprom), .mem_op_erase_all(),
		.mem_op_skip_ee(mem_op_skip_ee), .mem_op_addr(), .mem_op_mask(mem_op_mask),
		.fuse_addr(fuse_addr), .fuse_data(fuse_data)
	);
	always #20 mclk = ~mclk;
	// ----------------------------------------
	// Monitor of stall cycles and operation starts.
	// ----------------------------------------
	always @(posedge mclk)
	begin
		if (cpu_stall === 1'b1)
			stall_cnt++;
		if (mem_op_go === 1'b1)
		begin
			go_cnt++;
			go_cmd = mem_op_cmd;
			go_mask = mem_op_mask;
			go_skip = mem_op_skip_ee;
		end
	end
	// ----------------------------------------
	// Model, bus tasks and reporting.
	// ----------------------------------------
	function automatic logic [63:0] exp_mask();
		logic [63:0] m;
		m = 64'h0;
		foreach (marked[i])
			m[marked[i]] = 1'b1;
		return m;
	endfunction : exp_mask
	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : xs
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic store(input logic [15:0] a, input logic ee, input logic prot);
		@(posedge mclk);
		buf_wr        <= 1'b1;
		buf_addr      <= a;
		buf_wdata     <= xs();
		buf_is_eeprom <= ee;
		buf_prot_area <= prot;
		@(posedge mclk);
		buf_wr <= 1'b0;
		marked.push_back(int'(a[5:0]));
	endtask : store
	task automatic cmd(input logic [2:0] c, input int gap);
		@(posedge mclk);
		key_req <= 1'b1;
		@(posedge mclk);
		key_req <= 1'b0;
		repeat (gap) @(posedge mclk);
		g = go_cnt;
		stall_cnt = 0;
		wr(`NVC_OFS_CMD, {5'h00, c});
	endtask : cmd
	task automatic wait_idle();
		int n;
		n = 0;
		rv = 8'h03;
		while (rv[1:0] !== 2'b00 && n < 400)
		begin
			rd(`NVC_OFS_STATUS, rv);
			n++;
		end
		if (n >= 400)
		begin
			err_count++;
			final_report();
		end
		else
			repeat (3) @(posedge mclk);
	endtask : wait_idle
	task automatic done_op(input logic [2:0] c, input int steps, input logic [63:0] m);
		chk(64'(go_cnt - g), 64'(steps));
		chk(64'(go_cmd), 64'(c));
		chk(go_mask, m);
		chk(mem_op_mask, 64'h0);
		marked.delete();
	endtask : done_op
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		rd(`NVC_OFS_STATUS, rv);
		chk(64'(rv), 64'h0);
		rd(`NVC_OFS_IRQFLG, rv);
		chk(64'(rv[0]), 64'h1);
		rd(4'h5, rv);
		chk(64'(rv), 64'h0);
		store(16'h0200 | 16'(xs() & 8'h3f), 1'b0, 1'b0);
		cmd(nvc_pkg::NVC_CMD_WRITE, 8);
		repeat (4) @(posedge mclk);
		chk(64'(go_cnt - g), 64'h0);
		rd(`NVC_OFS_CMD, rv);
		chk(64'(rv[2:0]), 64'h0);
		$display("test key finished");
		cmd(nvc_pkg::NVC_CMD_WRITE, 0);
		wait_idle();
		chk(64'(stall_cnt >= 64), 64'h1);
		done_op(nvc_pkg::NVC_CMD_WRITE, 1, exp_mask());
		cmd(nvc_pkg::NVC_CMD_ERASE, 0);
		wait_idle();
		chk(64'(go_cnt - g), 64'h0);
		$display("test flash write finished");
		wr(`NVC_OFS_IRQEN, 8'h01);
		repeat (2) @(posedge mclk);
		chk(64'(irq), 64'h1);
		repeat (3) store(16'h1400 | 16'(xs() & 8'h3f), 1'b1, 1'b0);
		cmd(nvc_pkg::NVC_CMD_WRITE, 0);
		wr(`NVC_OFS_IRQFLG, 8'h01);
		repeat (2) @(posedge mclk);
		chk(64'(irq), 64'h0);
		rd(`NVC_OFS_STATUS, rv);
		chk(64'(rv[1:0]), 64'h2);
		wait_idle();
		chk(64'(irq), 64'h1);
		chk(64'(stall_cnt), 64'h0);
		done_op(nvc_pkg::NVC_CMD_WRITE, 1, exp_mask());
		store(16'h1410, 1'b1, 1'b0);
		cmd(nvc_pkg::NVC_CMD_ERASE, 0);
		wait_idle();
		chk(64'(stall_cnt), 64'h0);
		done_op(nvc_pkg::NVC_CMD_ERASE, 1, 64'h0001_0000);
		$display("test eeprom finished");
		repeat (2) store(16'h0300 | 16'(xs() & 8'h3f), 1'b0, 1'b0);
		cmd(nvc_pkg::NVC_CMD_ERWR, 1);
		wait_idle();
		chk(64'(stall_cnt >= 128), 64'h1);
		done_op(nvc_pkg::NVC_CMD_ERWR, 2, exp_mask());
		store(16'h0305, 1'b0, 1'b0);
		cmd(nvc_pkg::NVC_CMD_ERASE, 2);
		wait_idle();
		chk(64'(stall_cnt >= 64), 64'h1);
		done_op(nvc_pkg::NVC_CMD_ERASE, 1, exp_mask());
		store(16'h1422, 1'b1, 1'b0);
		cmd(nvc_pkg::NVC_CMD_PBC, 0);
		repeat (20) @(posedge mclk);
		chk(64'(stall_cnt), 64'h7);
		chk(mem_op_mask, 64'h0);
		marked.delete();
		cmd(nvc_pkg::NVC_CMD_EEPROM_ERASE_CMD, 0);
		wait_idle();
		chk(64'(stall_cnt > 0), 64'h1);
		chk(64'(go_cmd), 64'h6);
		preserve <= 1'b1;
		cmd(nvc_pkg::NVC_CMD_CHIP, 0);
		wait_idle();
		chk({61'h0, go_cmd}, 64'h5);
		chk(64'(go_skip), 64'h1);
		$display("test commands finished");
		cmd(nvc_pkg::NVC_CMD_FUSE, 0);
		repeat (4) @(posedge mclk);
		chk(64'(go_cnt - g), 64'h0);
		dbg_access <= 1'b1;
		wr(`NVC_OFS_ADDRL, 8'h05);
		wr(`NVC_OFS_ADDRH, 8'h12);
		wr(`NVC_OFS_DATAL, 8'hc3);
		wr(`NVC_OFS_DATAH, 8'h5a);
		wr(`NVC_OFS_CMD, 8'h07);
		wait_idle();
		chk(64'({fuse_addr, fuse_data}), 64'h1205_5ac3);
		dbg_access <= 1'b0;
		$display("test fuse finished");
		store(16'h0400, 1'b0, 1'b1);
		rd(`NVC_OFS_STATUS, rv);
		chk(64'(rv[2]), 64'h1);
		cmd(nvc_pkg::NVC_CMD_PBC, 0);
		rd(`NVC_OFS_STATUS, rv);
		chk(64'(rv[2]), 64'h0);
		marked.delete();
		wr(`NVC_OFS_LOCK, 8'h01);
		wr(`NVC_OFS_LOCK, 8'h00);
		rd(`NVC_OFS_LOCK, rv);
		chk(64'(rv[0]), 64'h1);
		@(posedge mclk);
		rv = xs() | 8'h01;
		mem_in <= rv;
		@(posedge mclk);
		#1;
		chk(64'(mem_rdata_out), 64'(rv));
		@(posedge mclk);
		in_boot <= 1'b1;
		wr(`NVC_OFS_LOCK, 8'h02);
		in_boot <= 1'b0;
		boot_acc <= 1'b1;
		@(posedge mclk);
		#1;
		chk(64'(mem_rdata_out), 64'h0);
		rd(`NVC_OFS_LOCK, rv);
		chk(64'(rv[1]), 64'h1);
		@(posedge mclk);
		boot_acc <= 1'b0;
		ce <= 1'b0;
		wr(`NVC_OFS_IRQEN, 8'h00);
		ce <= 1'b1;
		rd(`NVC_OFS_IRQEN, rv);
		chk(64'(rv[0]), 64'h1);
		$display("test lock finished");
		store(16'h1433, 1'b1, 1'b0);
		sleep_req <= 1'b1;
		@(posedge mclk);
		sleep_req <= 1'b0;
		rd(`NVC_OFS_SYSCTL, rv);
		chk(64'(rv[0]), 64'h1);
		chk(mem_op_mask, exp_mask());
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		rd(`NVC_OFS_SYSCTL, rv);
		chk(64'(rv[0]), 64'h0);
		chk(mem_op_mask, 64'h0);
		marked.delete();
		@(posedge mclk);
		sleep_idle <= 1'b1;
		sleep_req <= 1'b1;
		@(posedge mclk);
		sleep_req <= 1'b0;
		repeat (2) @(posedge mclk);
		sleep_idle <= 1'b0;
		rd(`NVC_OFS_SYSCTL, rv);
		chk(64'(rv[0]), 64'h0);
		$display("test sleep finished");
		store(16'h0500, 1'b0, 1'b0);
		cmd(nvc_pkg::NVC_CMD_WRITE, 0);
		repeat (6) @(posedge mclk);
		nrst <= 1'b0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		chk(64'(cpu_stall), 64'h0);
		rd(`NVC_OFS_STATUS, rv);
		chk(64'(rv), 64'h0);
		rd(`NVC_OFS_LOCK, rv);
		chk(64'(rv[0]), 64'h0);
		$display("test reset finished");
		final_report();
	end
endmodule : nvc_ctrl_tb

// File: nvc_op_timer.sv
// Down counter that times one memory operation step.
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_op_timer
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        load,
	input  wire logic [15:0] count,
	output logic             done
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        run;
		logic        done;
	} nvc_tmr_t;
	nvc_tmr_t s_q;
	nvc_tmr_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (load)
		begin
			s_d.cnt = count;
			s_d.run = 1'b1;
		end
		else if (s_q.run)
		begin
			if (s_q.cnt <= 16'h0001)
			begin
				s_d.run = 1'b0;
				s_d.done = 1'b1;
			end
			else
				s_d.cnt = s_q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign done = s_q.done & ce;
endmodule : nvc_op_timer

// File: nvc_pkg.sv
// Types of the nonvolatile memory command controller.
package nvc_pkg;
	typedef enum logic [2:0] {
		NVC_CMD_NONE  = 3'h0,
		NVC_CMD_WRITE = 3'h1,
		NVC_CMD_ERASE = 3'h2,
		NVC_CMD_ERWR  = 3'h3,
		NVC_CMD_PBC   = 3'h4,
		NVC_CMD_CHIP  = 3'h5,
		NVC_CMD_EEPROM_ERASE_CMD  = 3'h6,
		NVC_CMD_FUSE  = 3'h7
	} nvc_cmd_t;
	typedef enum logic [1:0] {
		NVC_ST_IDLE  = 2'h0,
		NVC_ST_ERASE = 2'h1,
		NVC_ST_WRITE = 2'h2,
		NVC_ST_CLEAR = 2'h3
	} nvc_state_t;
endpackage : nvc_pkg
